// [capc_pkg.sv]
// shared constants, field layouts and carriers for the alarm and power-control block
package capc_pkg;
	// register indices on the plain register port
	localparam logic [3:0] CAPC_OFF_ACFG = 4'h0;
	localparam logic [3:0] CAPC_OFF_MINSEC = 4'h1;
	localparam logic [3:0] CAPC_OFF_WDHR = 4'h2;
	localparam logic [3:0] CAPC_OFF_MTHDY = 4'h3;
	localparam logic [3:0] CAPC_OFF_PWRCTL = 4'h4;
	localparam logic [3:0] CAPC_OFF_WIN = 4'h5;
	localparam logic [3:0] CAPC_OFF_STAT = 4'h6;
	// implemented bits of the alarm value and alarm config registers
	localparam logic [15:0] CAPC_MASK_MINSEC = 16'h7f7f;
	localparam logic [15:0] CAPC_MASK_WDHR = 16'h073f;
	localparam logic [15:0] CAPC_MASK_MTHDY = 16'h1f3f;
	localparam logic [15:0] CAPC_MASK_ACFG = 16'hfcff;
	// power control register bit positions
	localparam int CAPC_PWR_ON_BIT = 15;
	localparam int CAPC_PWR_POL_BIT = 14;
	// status register bit positions
	localparam int CAPC_ST_WAKE_BIT = 0;
	localparam int CAPC_ST_SAMP_BIT = 1;
	localparam int CAPC_ST_SUPPLY_BIT = 2;
	localparam int CAPC_ST_PULSE_BIT = 3;
	// reset values, repeat counter codes and window length codes
	localparam logic [15:0] CAPC_RST_REG = 16'h0000;
	localparam logic [7:0] CAPC_RPT_ZERO = 8'h00;
	localparam logic [7:0] CAPC_RPT_WRAP = 8'hff;
	localparam logic [7:0] CAPC_WIN_ALWAYS = 8'hff;
	localparam logic [7:0] CAPC_WIN_NONE = 8'h00;
	// window tick divider default, in clk cycles per window tick
	localparam int CAPC_WIN_DIV_DEF = 32;
	// match interval codes
	localparam logic [3:0] CAPC_IV_HALF = 4'h0;
	localparam logic [3:0] CAPC_IV_SEC = 4'h1;
	localparam logic [3:0] CAPC_IV_SEC10 = 4'h2;
	localparam logic [3:0] CAPC_IV_MIN = 4'h3;
	localparam logic [3:0] CAPC_IV_MIN10 = 4'h4;
	localparam logic [3:0] CAPC_IV_HOUR = 4'h5;
	localparam logic [3:0] CAPC_IV_DAY = 4'h6;
	localparam logic [3:0] CAPC_IV_WEEK = 4'h7;
	localparam logic [3:0] CAPC_IV_MONTH = 4'h8;
	localparam logic [3:0] CAPC_IV_YEAR = 4'h9;

	// alarm configuration and repeat register layout
	typedef struct packed {
		logic alarm_on;
		logic endless_repeat;
		logic [3:0] match_interval_select;
		logic [1:0] unused;
		logic [7:0] repeat_counter;
	} capc_acfg_t;

	// calendar digits in bcd, as delivered by the clock/calendar
	typedef struct packed {
		logic mth_ten;
		logic [3:0] mth_one;
		logic [1:0] day_ten;
		logic [3:0] day_one;
		logic [2:0] wday;
		logic [1:0] hr_ten;
		logic [3:0] hr_one;
		logic [2:0] min_ten;
		logic [3:0] min_one;
		logic [2:0] sec_ten;
		logic [3:0] sec_one;
		logic half;
	} capc_time_t;

	// power control sequencer states
	typedef enum logic [1:0] {
		CAPC_PW_IDLE,
		CAPC_PW_SETTLE,
		CAPC_PW_SAMPLE
	} capc_pw_state_t;
endpackage

// [capc_win_timer.sv]
// down counter for one power-control window, counted in window ticks
module capc_win_timer #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// control
	input wire logic load,
	input wire logic [WIDTH-1:0] load_val,
	input wire logic tick,
	// result
	output logic [WIDTH-1:0] count,
	output logic done
);
	logic [WIDTH-1:0] cnt_reg;
	logic [WIDTH-1:0] cnt_next;
	localparam logic [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1};
	localparam logic [WIDTH-1:0] ZERO = '0;

	// load wins over counting; zero means idle and never expires
	always_comb begin
		cnt_next = cnt_reg;
		if (load) begin
			cnt_next = load_val;
		end else if (tick && cnt_reg != ZERO) begin
			cnt_next = cnt_reg - ONE;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt_reg <= ZERO;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	assign count = cnt_reg;
	assign done = tick && !load && cnt_reg == ONE;
endmodule // capc_win_timer

// [capc_alarm_power.sv]
// alarm comparator, repeat counter, alarm pulse and power-control sequencer
//
// Overview of operation
// - enable bit 15 of alarm config gates all alarm events
// - interval field bits 13:10 chooses which alarm digits must match
// - codes 0 to 9 give half second up to yearly periods
// - yearly alarm recurs each year, except one set on February 29
// - repeat counter bits 7:0; zero without endless repeat gives one alarm
// - each alarm decrements the counter; at zero last alarm clears enable
// - loading FFh gives repeated alarms before switching itself off
// - endless repeat bit 14 wraps counter zero to FFh, alarms continue
// - every alarm event raises an interrupt request
// - alarm pulse output toggles on every alarm, synchronous to timebase
// - power control switches external device on, settles, samples, off
// - polarity bit 14 chooses active low or active high supply control
// - settle length counts 1 to 255 ticks; zero samples at alarm
// - sample length 1 to 254 ticks; zero none; all ones always sampling
// - sample window starts when settle expires, unless settle length zero
// - month/day and weekday/hour alarm values writable only when unlocked
module capc_alarm_power
	import capc_pkg::*;
#(
	parameter int WIN_DIV = capc_pkg::CAPC_WIN_DIV_DEF
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// calendar timebase
	input wire capc_pkg::capc_time_t cal_time,
	input wire logic cal_tick,
	input wire logic time_write_unlock,
	// external device
	input wire logic wake_in,
	output logic switched_supply_control,
	output logic sample_window,
	// alarm outputs
	output logic alarm_irq,
	output logic alarm_pulse
);
	import capc_pkg::*;

	capc_acfg_t acfg_reg, acfg_next;
	logic [15:0] minsec_reg, minsec_next;
	logic [15:0] wdhr_reg, wdhr_next;
	logic [15:0] mthdy_reg, mthdy_next;
	logic [15:0] pwr_reg, pwr_next;
	logic [15:0] win_reg, win_next;
	logic [15:0] rdata_reg, rdata_next;
	logic match_prev_reg, match_prev_next;
	logic irq_reg, irq_next;
	logic pulse_reg, pulse_next;
	capc_time_t alm;
	logic match;
	logic fire;
	logic wr_acfg;
	logic [15:0] stat_word;

	// bus decode strobes
	assign wr_acfg = reg_wr && reg_addr == CAPC_OFF_ACFG;

	// alarm digits gathered from the three value registers
	always_comb begin
		alm = '0;
		alm.min_ten = minsec_reg[14:12];
		alm.min_one = minsec_reg[11:8];
		alm.sec_ten = minsec_reg[6:4];
		alm.sec_one = minsec_reg[3:0];
		alm.wday = wdhr_reg[10:8];
		alm.hr_ten = wdhr_reg[5:4];
		alm.hr_one = wdhr_reg[3:0];
		alm.mth_ten = mthdy_reg[12];
		alm.mth_one = mthdy_reg[11:8];
		alm.day_ten = mthdy_reg[5:4];
		alm.day_one = mthdy_reg[3:0];
	end

	// widening digit compare; a feb 29 alarm only matches in leap years
	always_comb begin
		logic m_sec1, m_sec10, m_min1, m_min10, m_hr, m_day;
		m_sec1 = !cal_time.half && cal_time.sec_one == alm.sec_one;
		m_sec10 = m_sec1 && cal_time.sec_ten == alm.sec_ten;
		m_min1 = m_sec10 && cal_time.min_one == alm.min_one;
		m_min10 = m_min1 && cal_time.min_ten == alm.min_ten;
		m_hr = m_min10 && cal_time.hr_one == alm.hr_one && cal_time.hr_ten == alm.hr_ten;
		m_day = m_hr && cal_time.day_one == alm.day_one && cal_time.day_ten == alm.day_ten;
		case (acfg_reg.match_interval_select)
			CAPC_IV_HALF: match = 1'b1;
			CAPC_IV_SEC: match = !cal_time.half;
			CAPC_IV_SEC10: match = m_sec1;
			CAPC_IV_MIN: match = m_sec10;
			CAPC_IV_MIN10: match = m_min1;
			CAPC_IV_HOUR: match = m_min10;
			CAPC_IV_DAY: match = m_hr;
			CAPC_IV_WEEK: match = m_hr && cal_time.wday == alm.wday;
			CAPC_IV_MONTH: match = m_day;
			CAPC_IV_YEAR: match = m_day && cal_time.mth_one == alm.mth_one
				&& cal_time.mth_ten == alm.mth_ten;
			default: match = 1'b0;
		endcase
	end

	// fire on the tick where the match first appears; half-second mode fires every tick
	assign fire = cal_tick && acfg_reg.alarm_on && (acfg_reg.match_interval_select == CAPC_IV_HALF
		|| (match && !match_prev_reg));

	// alarm config, repeat counter and alarm outputs; a hardware alarm overrides the repeat counter or enable bit of a same-cycle write
	always_comb begin
		acfg_next = acfg_reg;
		match_prev_next = match_prev_reg;
		irq_next = fire;
		pulse_next = pulse_reg ^ fire;
		if (cal_tick) begin
			match_prev_next = match;
		end
		if (wr_acfg) begin
			acfg_next = capc_acfg_t'(reg_wdata & CAPC_MASK_ACFG);
		end
		if (fire) begin
			if (acfg_reg.repeat_counter != CAPC_RPT_ZERO) begin
				acfg_next.repeat_counter = acfg_reg.repeat_counter - 8'h01;
			end else if (acfg_reg.endless_repeat) begin
				acfg_next.repeat_counter = CAPC_RPT_WRAP;
			end else begin
				acfg_next.alarm_on = 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			acfg_reg <= capc_acfg_t'(CAPC_RST_REG);
			match_prev_reg <= 1'b0;
			irq_reg <= 1'b0;
			pulse_reg <= 1'b0;
		end else begin
			acfg_reg <= acfg_next;
			match_prev_reg <= match_prev_next;
			irq_reg <= irq_next;
			pulse_reg <= pulse_next;
		end
	end

	// value and power registers; weekday/hour, month/day and windows stay locked without unlock
	always_comb begin
		minsec_next = minsec_reg;
		wdhr_next = wdhr_reg;
		mthdy_next = mthdy_reg;
		pwr_next = pwr_reg;
		win_next = win_reg;
		if (reg_wr) begin
			if (reg_addr == CAPC_OFF_MINSEC) begin
				minsec_next = reg_wdata & CAPC_MASK_MINSEC;
			end else if (reg_addr == CAPC_OFF_WDHR && time_write_unlock) begin
				wdhr_next = reg_wdata & CAPC_MASK_WDHR;
			end else if (reg_addr == CAPC_OFF_MTHDY && time_write_unlock) begin
				mthdy_next = reg_wdata & CAPC_MASK_MTHDY;
			end else if (reg_addr == CAPC_OFF_PWRCTL) begin
				pwr_next = {reg_wdata[15:14], 14'h0000};
			end else if (reg_addr == CAPC_OFF_WIN && time_write_unlock) begin
				win_next = reg_wdata;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			minsec_reg <= CAPC_RST_REG;
			wdhr_reg <= CAPC_RST_REG;
			mthdy_reg <= CAPC_RST_REG;
			pwr_reg <= CAPC_RST_REG;
			win_reg <= CAPC_RST_REG;
		end else begin
			minsec_reg <= minsec_next;
			wdhr_reg <= wdhr_next;
			mthdy_reg <= mthdy_next;
			pwr_reg <= pwr_next;
			win_reg <= win_next;
		end
	end

	// window tick divider: one-cycle enable every WIN_DIV clocks
	localparam logic [15:0] DIV_LAST = 16'(WIN_DIV - 1);
	logic [15:0] div_reg, div_next;
	logic win_tick;
	assign win_tick = div_reg == DIV_LAST;
	always_comb begin
		div_next = win_tick ? 16'h0000 : div_reg + 16'h0001;
	end

	// wake input from the external device crosses in through two flops
	logic wake_s1_reg, wake_s2_reg;

	// power sequencer state
	capc_pw_state_t pw_reg, pw_next;
	logic [7:0] settle_len, sample_len;
	logic pwr_on, pwr_pol;
	logic settle_load, sample_load, settle_done, sample_done;
	logic supply_active, samp_active;
	logic wake_seen_reg, wake_seen_next;
	logic supply_reg, supply_next;
	logic samp_reg, samp_next;
	assign settle_len = win_reg[15:8];
	assign sample_len = win_reg[7:0];
	assign pwr_on = pwr_reg[CAPC_PWR_ON_BIT];
	assign pwr_pol = pwr_reg[CAPC_PWR_POL_BIT];

	capc_win_timer #(.WIDTH(8)) u_settle (
		.clk(clk),
		.rstn(rstn),
		.load(settle_load),
		.load_val(settle_len),
		.tick(win_tick),
		.count(),
		.done(settle_done)
	);

	capc_win_timer #(.WIDTH(8)) u_sample (
		.clk(clk),
		.rstn(rstn),
		.load(sample_load),
		.load_val(sample_len),
		.tick(win_tick),
		.count(),
		.done(sample_done)
	);

	// alarm powers the device up; settle, then sample, then power down
	always_comb begin
		pw_next = pw_reg;
		settle_load = 1'b0;
		sample_load = 1'b0;
		case (pw_reg)
			CAPC_PW_IDLE: begin
				if (fire && pwr_on) begin
					if (settle_len != CAPC_WIN_NONE) begin
						pw_next = CAPC_PW_SETTLE;
						settle_load = 1'b1;
					end else if (sample_len != CAPC_WIN_NONE) begin
						pw_next = CAPC_PW_SAMPLE;
						sample_load = 1'b1;
					end
				end
			end
			CAPC_PW_SETTLE: begin
				if (settle_done) begin
					sample_load = 1'b1;
					pw_next = (sample_len != CAPC_WIN_NONE) ? CAPC_PW_SAMPLE : CAPC_PW_IDLE;
				end
			end
			CAPC_PW_SAMPLE: begin
				if (sample_done) begin
					pw_next = CAPC_PW_IDLE;
				end
			end
			default: pw_next = CAPC_PW_IDLE;
		endcase
		// turning power control off drops the supply at once
		if (!pwr_on) begin
			pw_next = CAPC_PW_IDLE;
		end
	end

	// outputs; all ones in the sample length keeps sampling open regardless of sequencer
	always_comb begin
		supply_active = pw_next != CAPC_PW_IDLE;
		samp_active = pw_next == CAPC_PW_SAMPLE || sample_len == CAPC_WIN_ALWAYS;
		supply_next = pwr_pol ? supply_active : !supply_active;
		samp_next = samp_active;
		wake_seen_next = wake_seen_reg;
		if (reg_wr && reg_addr == CAPC_OFF_STAT && reg_wdata[CAPC_ST_WAKE_BIT]) begin
			wake_seen_next = 1'b0;
		end
		// a wake event in the clearing cycle still sets the flag
		if (samp_reg && wake_s2_reg) begin
			wake_seen_next = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			div_reg <= 16'h0000;
			wake_s1_reg <= 1'b0;
			wake_s2_reg <= 1'b0;
			pw_reg <= CAPC_PW_IDLE;
			supply_reg <= 1'b1;
			samp_reg <= 1'b0;
			wake_seen_reg <= 1'b0;
		end else begin
			div_reg <= div_next;
			wake_s1_reg <= wake_in;
			wake_s2_reg <= wake_s1_reg;
			pw_reg <= pw_next;
			supply_reg <= supply_next;
			samp_reg <= samp_next;
			wake_seen_reg <= wake_seen_next;
		end
	end

	// read mux, data valid the cycle after the strobe; unmapped reads zero
	always_comb begin
		stat_word = 16'h0000;
		stat_word[CAPC_ST_WAKE_BIT] = wake_seen_reg;
		stat_word[CAPC_ST_SAMP_BIT] = samp_reg;
		stat_word[CAPC_ST_SUPPLY_BIT] = pw_reg != CAPC_PW_IDLE;
		stat_word[CAPC_ST_PULSE_BIT] = pulse_reg;
		rdata_next = 16'h0000;
		if (reg_rd) begin
			if (reg_addr == CAPC_OFF_ACFG) begin
				rdata_next = acfg_reg;
			end else if (reg_addr == CAPC_OFF_MINSEC) begin
				rdata_next = minsec_reg;
			end else if (reg_addr == CAPC_OFF_WDHR) begin
				rdata_next = wdhr_reg;
			end else if (reg_addr == CAPC_OFF_MTHDY) begin
				rdata_next = mthdy_reg;
			end else if (reg_addr == CAPC_OFF_PWRCTL) begin
				rdata_next = pwr_reg;
			end else if (reg_addr == CAPC_OFF_WIN) begin
				rdata_next = win_reg;
			end else if (reg_addr == CAPC_OFF_STAT) begin
				rdata_next = stat_word;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_reg <= 16'h0000;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;
	assign alarm_irq = irq_reg;
	assign alarm_pulse = pulse_reg;
	assign switched_supply_control = supply_reg;
	assign sample_window = samp_reg;

	// checks on the alarm path
	alarm_off_quiet_a: assert property (@(posedge clk) disable iff (!rstn)
		!acfg_reg.alarm_on |=> !irq_reg) else $error("alarm fired while disabled");
	irq_on_fire_a: assert property (@(posedge clk) disable iff (!rstn)
		fire |=> irq_reg ##1 !irq_reg || $past(fire)) else $error("irq not raised for alarm");
	pulse_toggle_a: assert property (@(posedge clk) disable iff (!rstn)
		fire |=> alarm_pulse != $past(alarm_pulse)) else $error("alarm pulse did not toggle");
	half_every_a: assert property (@(posedge clk) disable iff (!rstn)
		cal_tick && acfg_reg.alarm_on && acfg_reg.match_interval_select == CAPC_IV_HALF |=> alarm_irq)
		else $error("half second alarm missed");
	first_match_a: assert property (@(posedge clk) disable iff (!rstn)
		fire && acfg_reg.match_interval_select == CAPC_IV_MIN |-> !cal_time.half && cal_time.sec_one == minsec_reg[3:0]
		&& cal_time.sec_ten == minsec_reg[6:4]) else $error("minute alarm without a seconds match");
	repeat_dec_a: assert property (@(posedge clk) disable iff (!rstn)
		fire && !wr_acfg && acfg_reg.repeat_counter != 8'h00
		|=> acfg_reg.repeat_counter == $past(acfg_reg.repeat_counter) - 8'h01 && acfg_reg.alarm_on)
		else $error("repeat counter not decremented");
	last_alarm_off_a: assert property (@(posedge clk) disable iff (!rstn)
		fire && !wr_acfg && acfg_reg.repeat_counter == 8'h00 && !acfg_reg.endless_repeat
		|=> !acfg_reg.alarm_on ##1 !irq_reg) else $error("enable not cleared after last alarm");
	endless_wrap_a: assert property (@(posedge clk) disable iff (!rstn)
		fire && !wr_acfg && acfg_reg.repeat_counter == 8'h00 && acfg_reg.endless_repeat
		|=> acfg_reg.repeat_counter == 8'hff && acfg_reg.alarm_on) else $error("endless repeat did not wrap");
	// checks on the power path and the alarm date write lock
	zero_settle_a: assert property (@(posedge clk) disable iff (!rstn)
		pw_reg == CAPC_PW_IDLE && fire && pwr_on && settle_len == 8'h00 && sample_len != 8'h00
		|=> pw_reg == CAPC_PW_SAMPLE && sample_window) else $error("sampling did not start at alarm");
	supply_pol_a: assert property (@(posedge clk) disable iff (!rstn)
		$stable(pwr_pol) && pw_reg != CAPC_PW_IDLE && $past(pw_reg) != CAPC_PW_IDLE
		|-> switched_supply_control == pwr_pol) else $error("supply level wrong for polarity");
	locked_write_a: assert property (@(posedge clk) disable iff (!rstn)
		reg_wr && reg_addr == CAPC_OFF_MTHDY && !time_write_unlock |=> $stable(mthdy_reg))
		else $error("locked alarm date written");
	always_sample_a: assert property (@(posedge clk) disable iff (!rstn)
		sample_len == 8'hff && $past(sample_len) == 8'hff |-> sample_window)
		else $error("sampling not held open");
endmodule // capc_alarm_power

// [capc_ext_dev.sv]
// behavioural model of the external device whose supply the block switches
module capc_ext_dev (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// supply switch, its active level and the wish to raise a wake event
	input wire logic supply,
	input wire logic active_high,
	input wire logic want_wake,
	// wake event line, pulled low while the device is unpowered
	output logic wake_in
);
	timeunit 1ns;
	timeprecision 1ps;

	// a dead device cannot wake anyone, so the pull-down wins while off
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			wake_in <= 1'b0;
		else
			wake_in <= want_wake && (supply == active_high);
	end
endmodule // capc_ext_dev

// [capc_alarm_power_bench.sv]
// self-checking bench for the alarm and power-control block
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin num_errors++; $display("ERROR %s expected %h seen %h", nm, e, g); end end
module capc_alarm_power_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import capc_pkg::*;

	localparam int WDIV = 2;
	logic clk, rstn, reg_wr, reg_rd, cal_tick, time_write_unlock, wake_in, pol, want_wake;
	logic switched_supply_control, sample_window, alarm_irq, alarm_pulse, irq;
	logic [3:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, q, d, ms, wd, md;
	capc_time_t cal_time, t;
	int num_errors = 0;
	int tests_run = 0;
	int n, w, len, st;
	// per unlock state: bits that a write leaves behind
	logic [15:0] msk [2][8] = '{'{16'hfcff, 16'h7f7f, 16'h0000, 16'h0000, 16'hc000, 16'h0000, 16'h0000, 16'h0000},
		'{16'hfcff, 16'h7f7f, 16'h073f, 16'h1f3f, 16'hc000, 16'hffff, 16'h0000, 16'h0000}};
	logic [7:0] rl [3] = '{8'h00, 8'h02, 8'hff};

	capc_alarm_power #(.WIN_DIV(WDIV)) dut_u (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cal_time(cal_time), .cal_tick(cal_tick),
		.time_write_unlock(time_write_unlock), .wake_in(wake_in), .switched_supply_control(switched_supply_control),
		.sample_window(sample_window), .alarm_irq(alarm_irq), .alarm_pulse(alarm_pulse));
	capc_ext_dev dev_u (.clk(clk), .rstn(rstn), .supply(switched_supply_control), .active_high(pol),
		.want_wake(want_wake), .wake_in(wake_in));

	// 20 MHz clock
	always #25 clk = ~clk;

	// one write cycle on the register port
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	// read strobe, then data taken in the single cycle it stands
	task automatic rd(input logic [3:0] a, output logic [15:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	// one timebase tick carrying the given digits; pulse must flip with irq
	task automatic tick(input capc_time_t tv, output logic fired);
		logic p0;
		p0 = alarm_pulse;
		@(posedge clk);
		cal_time <= tv;
		cal_tick <= 1'b1;
		@(posedge clk);
		cal_tick <= 1'b0;
		#1 fired = alarm_irq;
		`CHK("alarm_pulse", p0 ^ fired, alarm_pulse)
	endtask

	// whether interval code c fires on a tick, given digit agreement and a fresh match
	function automatic logic exp_fire(input int c, input logic hit, input logic fresh);
		return c == 0 || (c < 10 && hit && fresh);
	endfunction

	task give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// watchdog well beyond the expected run length
	initial begin
		#(50 * 60000);
		num_errors++;
		give_verdict;
	end

	initial begin
		void'($urandom(92));
		clk = 1'b0;
		rstn = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		cal_time = '0;
		cal_tick = 1'b0;
		time_write_unlock = 1'b0;
		pol = 1'b0;
		want_wake = 1'b1;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		`CHK("supply_rst", 1'b1, switched_supply_control)
		for (int a = 0; a < 8; a++) begin
			rd(4'(a), q);
			`CHK("reg_reset", 16'h0000, q)
		end
		// locked then unlocked writes, unmapped index included
		for (int u = 0; u < 2; u++) begin
			@(posedge clk);
			time_write_unlock <= u[0];
			for (int a = 0; a < 8; a++) if (a != 6) begin
				d = 16'($urandom);
				wr(4'(a), d);
				rd(4'(a), q);
				`CHK("reg_access", d & msk[u][a], q)
			end
		end
		for (int a = 0; a < 6; a++) wr(4'(a), 16'h0000);
		$display("test registers done");

		// interval codes 0 to 11, including the unused codes 10 and 11
		for (int c = 0; c < 12; c++) begin
			ms = 16'($urandom) & CAPC_MASK_MINSEC;
			wd = 16'($urandom) & CAPC_MASK_WDHR;
			md = 16'($urandom) & CAPC_MASK_MTHDY;
			wr(CAPC_OFF_ACFG, 16'h0000); // alarm off before values change
			wr(CAPC_OFF_MINSEC, ms);
			wr(CAPC_OFF_WDHR, wd);
			wr(CAPC_OFF_MTHDY, md);
			t = {md[12:8], md[5:0], wd[10:8], wd[5:0], ms[14:8], ms[6:0], 1'b0};
			wr(CAPC_OFF_ACFG, {2'b11, 4'(c), 10'h000}); // written between ticks
			n = 0;
			tick(~t, irq);
			`CHK("irq_nomatch", exp_fire(c, 1'b0, 1'b1), irq)
			n += int'(irq);
			tick(t, irq);
			`CHK("irq_match", exp_fire(c, 1'b1, 1'b1), irq)
			n += int'(irq);
			tick(t, irq);
			`CHK("irq_again", exp_fire(c, 1'b1, 1'b0), irq)
			n += int'(irq);
			rd(CAPC_OFF_ACFG, q);
			`CHK("acfg_wrap", {2'b11, 4'(c), 2'b00, 8'(0 - n)}, q)
		end
		$display("test intervals done");

		// repeat counts, one alarm more than loaded, then self-disable
		for (int i = 0; i < 3; i++) begin
			wr(CAPC_OFF_ACFG, {2'b10, CAPC_IV_HALF, 2'b00, rl[i]});
			n = 0;
			repeat (int'(rl[i]) + 3) begin
				tick(t, irq);
				n += int'(irq);
			end
			`CHK("alarm_count", int'(rl[i]) + 1, n)
			rd(CAPC_OFF_ACFG, q);
			`CHK("acfg_off", {2'b00, CAPC_IV_HALF, 10'h000}, q)
		end
		$display("test repeats done");

		// power cycles, both polarities, with and without settle window
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			pol <= i[0];
			want_wake <= 1'(i != 1);
			st = i[1] ? 3 : 0;
			wr(CAPC_OFF_WIN, {8'(st), 8'h03});
			wr(CAPC_OFF_PWRCTL, {1'b1, i[0], 14'h0000});
			wr(CAPC_OFF_STAT, 16'h0001);
			wr(CAPC_OFF_ACFG, {2'b11, CAPC_IV_HALF, 10'h000}); // endless repeat keeps power cycles periodic
			tick(t, irq);
			`CHK("supply_on", i[0], switched_supply_control)
			w = 1;
			while (sample_window !== 1'b1 && w < 100) begin
				@(posedge clk);
				#1 w++;
			end
			`CHK("settle_len", 1'b1, 1'((st == 0) ? (w <= 2) : (w > (st - 1) * WDIV && w <= st * WDIV + 2)))
			len = 0;
			while (sample_window === 1'b1 && len < 100) begin
				@(posedge clk);
				#1 len++;
			end
			`CHK("sample_len", 1'b1, 1'(len > 2 * WDIV && len <= 3 * WDIV + 1))
			`CHK("supply_off", ~i[0], switched_supply_control)
			rd(CAPC_OFF_STAT, q);
			`CHK("wake_seen", 1'(i != 1), q[CAPC_ST_WAKE_BIT])
			`CHK("stat_idle", 2'b00, {q[CAPC_ST_SUPPLY_BIT], q[CAPC_ST_SAMP_BIT]})
			`CHK("stat_pulse", alarm_pulse, q[CAPC_ST_PULSE_BIT])
		end
		// all-ones sample length samples even with power control off
		wr(CAPC_OFF_PWRCTL, 16'h0000);
		wr(CAPC_OFF_WIN, 16'h00ff);
		repeat (2) @(posedge clk);
		#1 `CHK("sample_always", 1'b1, sample_window)
		wr(CAPC_OFF_WIN, 16'h0000);
		repeat (2) @(posedge clk);
		#1 `CHK("sample_none", 1'b0, sample_window)
		$display("test power done");
		give_verdict;
	end
endmodule // capc_alarm_power_bench
